// ### dv/cgm_clk_src.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// crystal and vco pin model
module cgm_clk_src (
  // control side
  input wire logic i_oscillator_enable_in,
  input wire logic i_pll_power_on,
  input wire logic [3:0] i_mult,
  // clock pins
  output logic o_crystal_clock,
  output logic o_vco_clock
);
  localparam int XHALF = 200; // crystal half period, ns
  initial begin
    o_crystal_clock = 1'b0;
    forever begin
      if (i_oscillator_enable_in) #XHALF o_crystal_clock = ~o_crystal_clock;
      else begin
        o_crystal_clock = 1'b0;
        @(posedge i_oscillator_enable_in);
      end
    end
  end
  // vco at mult times reference, still when off
  initial begin
    o_vco_clock = 1'b0;
    #37;
    forever begin
      if (i_pll_power_on) #(XHALF / int'(i_mult)) o_vco_clock = ~o_vco_clock;
      else begin
        o_vco_clock = 1'b0;
        @(posedge i_pll_power_on);
      end
    end
  end
endmodule // cgm_clk_src
`default_nettype wire

// ### dv/cgm_pll_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port-level checker for the pll control block
module cgm_pll_ctrl_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // clocks and control
  input wire logic i_oscillator_enable_in,
  input wire logic o_crystal_amp_enable,
  input wire logic o_pll_power_on,
  input wire logic [3:0] o_vco_range,
  input wire logic o_pll_reference_clock,
  input wire logic o_final_reference_clock,
  input wire logic o_base_clock_out,
  input wire logic o_clockgen_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // access phase and unmapped decode
  wire logic acc = i_psel && i_penable;
  wire logic unmapped = i_paddr != 8'h00 && i_paddr != 8'h04 && i_paddr != 8'h08;
  // oscillator held off for a while
  sequence s_osc_dead;
    !i_oscillator_enable_in [*8];
  endsequence
  // read access of the control register
  sequence s_ctrl_read;
    acc && !i_pwrite && i_paddr == 8'h00;
  endsequence
  a_amp_follows_en: assert property (o_crystal_amp_enable == i_oscillator_enable_in)
    else $error("amp enable differs from oscillator enable");
  a_ref_gated: assert property (!i_oscillator_enable_in [*2] |-> !o_pll_reference_clock)
    else $error("reference clock runs while oscillator off");
  a_final_ref_copy: assert property (o_final_reference_clock == $past(o_pll_reference_clock))
    else $error("final reference is not a copy");
  a_power_needs_l: assert property (o_pll_power_on |-> o_vco_range != 4'h0)
    else $error("pll powered with zero range factor");
  a_unmapped_err: assert property (acc |-> o_pslverr == unmapped)
    else $error("slave error does not match decode");
  a_ppg_locked: assert property (acc && i_pwrite && i_paddr == 8'h08 && o_pll_power_on
    |=> $stable(o_vco_range)) else $error("multiplier changed while pll on");
  a_read_clears: assert property (s_ctrl_read ##0 o_clockgen_irq |=> !o_clockgen_irq)
    else $error("control read left interrupt up");
  a_base_held: assert property (s_osc_dead |-> $stable(o_base_clock_out))
    else $error("base clock moves with no source");
  a_upper_zero: assert property (o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule // cgm_pll_ctrl_monitor
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic i_oscillator_enable_in = 1'b1, xtal, vco, o_pready, o_pslverr, o_pll_power_on;
  logic o_pll_reference_clock, o_base_clock_out, o_track_mode, o_clockgen_irq, err, fbclk;
  logic [3:0] mult = 4'h1, o_vco_range;
  int failures = 0, num_checks = 0, cycles = 0, cnt, i;
  always #10 i_core_clk = ~i_core_clk;
  cgm_clk_src i_cgm_clk_src (.i_oscillator_enable_in(i_oscillator_enable_in),
    .i_pll_power_on(o_pll_power_on), .i_mult(mult), .o_crystal_clock(xtal), .o_vco_clock(vco));
  cgm_pll_ctrl i_cgm_pll_ctrl (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_crystal_clock(xtal),
    .i_vco_clock(vco), .i_oscillator_enable_in(i_oscillator_enable_in),
    .o_crystal_amp_enable(), .o_pll_power_on(o_pll_power_on), .o_vco_range(o_vco_range),
    .o_pll_reference_clock(o_pll_reference_clock), .o_final_reference_clock(),
    .o_vco_feedback_clock(fbclk), .o_base_clock_out(o_base_clock_out), .o_pump_up(),
    .o_pump_down(), .o_track_mode(o_track_mode), .o_clockgen_irq(o_clockgen_irq));
  // ==========================================================
  // bus cycle, compare and closing report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // count level changes of feedback (sel 1) or base clock (sel 0) over n cycles
  task automatic count_chg(input int sel, input int n);
    logic p, s;
    cnt = 0;
    p = sel ? fbclk : o_base_clock_out;
    repeat (n) begin
      @(posedge i_core_clk);
      s = sel ? fbclk : o_base_clock_out;
      if (s !== p) cnt++;
      p = s;
    end
  endtask
  task automatic results;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(8'h00, 32'h20);
    rd(8'h04, 32'h00);
    rd(8'h08, 32'h11);
    rd(8'h0C, 32'h00);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_manual;
    apb(1'b1, 8'h04, 32'h20);
    rd(8'h04, 32'h20);
    chk({31'h0, o_track_mode}, 32'h1);
    apb(1'b1, 8'h00, 32'hA0);
    rd(8'h00, 32'h20);
    apb(1'b1, 8'h04, 32'h00);
    chk({31'h0, o_track_mode}, 32'h0);
    $display("test manual done");
  endtask
  task automatic t_program;
    apb(1'b1, 8'h08, 32'h21);
    rd(8'h08, 32'h11);
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h08, 32'h20);
    apb(1'b1, 8'h00, 32'h30);
    rd(8'h00, 32'h20);
    chk({31'h0, o_pll_power_on}, 32'h0);
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h08, 32'h21);
    mult <= 4'h2;
    apb(1'b1, 8'h00, 32'h20);
    chk({28'h0, o_vco_range}, 32'h1);
    $display("test program done");
  endtask
  task automatic t_auto;
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h00, 32'hA0);
    for (i = 0; i < 8000 && o_clockgen_irq !== 1'b1; i++) @(posedge i_core_clk);
    chk({31'h0, o_clockgen_irq}, 32'h1);
    rd(8'h04, 32'hE0);
    rd(8'h00, 32'hE0);
    rd(8'h00, 32'hA0);
    chk({31'h0, o_clockgen_irq}, 32'h0);
    count_chg(1, 400);
    chk({31'h0, cnt >= 38 && cnt <= 42}, 32'h1);
    $display("test auto done");
  endtask
  task automatic t_select;
    apb(1'b1, 8'h00, 32'hB0);
    @(posedge i_core_clk);
    count_chg(0, 30);
    chk(cnt, 32'h0);
    apb(1'b1, 8'h00, 32'h90);
    rd(8'h00, 32'hB0);
    repeat (100) @(posedge i_core_clk);
    count_chg(0, 400);
    chk({31'h0, cnt >= 36 && cnt <= 44}, 32'h1);
    apb(1'b1, 8'h00, 32'hA0);
    repeat (100) @(posedge i_core_clk);
    $display("test select done");
  endtask
  task automatic t_osc_off;
    i_oscillator_enable_in <= 1'b0;
    repeat (40) @(posedge i_core_clk);
    chk({30'h0, o_pll_power_on, o_pll_reference_clock}, 32'h0);
    i_oscillator_enable_in <= 1'b1;
    repeat (40) @(posedge i_core_clk);
    $display("test osc_off done");
  endtask
  // ==========================================================
  // hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    t_reset();
    t_manual();
    t_program();
    t_auto();
    t_select();
    t_osc_off();
    results();
  end
endmodule // tb_top
bind cgm_pll_ctrl cgm_pll_ctrl_monitor i_cgm_pll_ctrl_monitor (.i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_oscillator_enable_in(i_oscillator_enable_in), .o_crystal_amp_enable(o_crystal_amp_enable),
  .o_pll_power_on(o_pll_power_on), .o_vco_range(o_vco_range),
  .o_pll_reference_clock(o_pll_reference_clock), .o_final_reference_clock(o_final_reference_clock),
  .o_base_clock_out(o_base_clock_out), .o_clockgen_irq(o_clockgen_irq));
`default_nettype wire

// ### src/cgm_map.vh
`ifndef CGM_MAP_VH
`define CGM_MAP_VH
// ==========================================================
// register byte offsets
`define CGM_PLL_CONTROL_REG_ADDR 8'h00
`define CGM_BANDWIDTH_CONTROL_REG_ADDR 8'h04
`define CGM_PPG_ADDR 8'h08
// pll control register fields
`define CGM_PLL_CONTROL_REG_IE 7
`define CGM_PLL_CONTROL_REG_FLAG 6
`define CGM_PLL_CONTROL_REG_ON 5
`define CGM_PLL_CONTROL_REG_BCS 4
// bandwidth control register fields
`define CGM_BANDWIDTH_CONTROL_REG_AUTO 7
`define CGM_BANDWIDTH_CONTROL_REG_LOCK 6
`define CGM_BANDWIDTH_CONTROL_REG_ACQ 5
// reset values
`define CGM_PPG_RESET 8'h11
`define CGM_ON_RESET 1'b1
// transition control: edges of each source, and fallback limit
`define CGM_SW_EDGES 2'h3
`define CGM_SW_TIMEOUT 8'hFF
// lock detector window (reference edges) and tolerances (feedback edges)
`define CGM_WIN 8'h10
`define CGM_TOL_TRK 8'h01
`define CGM_TOL_UNT 8'h02
`define CGM_TOL_LOCK 8'h00
`define CGM_TOL_UNL 8'h01
`endif

// ### src/cgm_pll_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "cgm_map.vh"
module cgm_pll_ctrl (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // clock inputs and system integration module
  input wire i_crystal_clock,
  input wire i_vco_clock,
  input wire i_oscillator_enable_in,
  // oscillator and vco control
  output wire o_crystal_amp_enable,
  output wire o_pll_power_on,
  output wire [3:0] o_vco_range,
  // derived clocks
  output reg o_pll_reference_clock,
  output reg o_final_reference_clock,
  output reg o_vco_feedback_clock,
  output reg o_base_clock_out,
  // loop filter
  output reg o_pump_up,
  output reg o_pump_down,
  output wire o_track_mode,
  // interrupt
  output wire o_clockgen_irq
);
  // ==========================================================
  // registers
  reg irq_enable; // interrupt enable
  reg lock_change_flag; // sticky lock toggle flag
  reg pll_power_on; // pll on bit
  reg base_clock_select; // requested vco select
  reg auto_bw; // automatic bandwidth select
  reg acquire_track_bit; // filter mode, 1 = tracking
  reg lock_ind; // lock indicator
  reg [7:0] multiplier_program_reg; // N and L

  wire [3:0] mult_n = multiplier_program_reg[7:4];
  wire [3:0] mult_l = multiplier_program_reg[3:0];
  wire pll_enabled = pll_power_on & (mult_l != 4'h0);
  wire bcs_eff = base_clock_select & pll_enabled;

  // ==========================================================
  // apb decode
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite;
  wire rd = acc & ~i_pwrite;
  wire hit_pll_control_reg = (i_paddr == `CGM_PLL_CONTROL_REG_ADDR);
  wire hit_bandwidth_control_reg = (i_paddr == `CGM_BANDWIDTH_CONTROL_REG_ADDR);
  wire hit_ppg = (i_paddr == `CGM_PPG_ADDR);
  wire hit_any = hit_pll_control_reg | hit_bandwidth_control_reg | hit_ppg;

  // zero wait states; unmapped gives an error
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~hit_any;

  // ==========================================================
  // pin synchronisers
  wire xtal_lvl;
  wire xtal_rise_raw;
  wire vco_lvl;
  wire vco_rise_raw;

  cgm_sync u_sync_xtal (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_crystal_clock),
    .o_level(xtal_lvl),
    .o_rise(xtal_rise_raw)
  );

  cgm_sync u_sync_vco (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_vco_clock),
    .o_level(vco_lvl),
    .o_rise(vco_rise_raw)
  );

  assign o_crystal_amp_enable = i_oscillator_enable_in;
  wire xtal_rise = xtal_rise_raw & i_oscillator_enable_in;
  // divider, detector and ST_RUN ignore vco edges while pll disabled; ST_SWITCH counts raw vco edges
  wire vco_rise = vco_rise_raw & pll_enabled;
  assign o_pll_power_on = pll_enabled & i_oscillator_enable_in;
  assign o_vco_range = mult_l;

  // ==========================================================
  // reference path
  // buffered crystal copies
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_pll_reference_clock <= 1'b0;
      o_final_reference_clock <= 1'b0;
    end else begin
      o_pll_reference_clock <= xtal_lvl & i_oscillator_enable_in;
      o_final_reference_clock <= o_pll_reference_clock;
    end
  end

  // ==========================================================
  // feedback divider
  reg [3:0] div_cnt; // vco edges within one period
  reg fb_rise; // feedback rising pulse
  wire [3:0] n_eff = (mult_n == 4'h0) ? 4'h1 : mult_n;
  wire [4:0] n_sum = {1'b0, n_eff} + 5'h01; // N plus one, no wrap at 15
  wire [3:0] n_half = n_sum[4:1];
  wire [3:0] div_inc = div_cnt + 4'h1;

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      div_cnt <= 4'h0;
      fb_rise <= 1'b0;
      o_vco_feedback_clock <= 1'b0;
    end else begin
      fb_rise <= 1'b0;
      if (vco_rise) begin
        if (div_inc >= n_eff) begin
          // wrap: start of feedback period
          div_cnt <= 4'h0;
          fb_rise <= 1'b1;
          o_vco_feedback_clock <= 1'b1;
        end else begin
          div_cnt <= div_inc;
          o_vco_feedback_clock <= (div_inc < n_half);
        end
      end
    end
  end

  // ==========================================================
  // phase detector
  reg ref_rise_d; // reference edge aligned to fb_rise timing
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ref_rise_d <= 1'b0;
    end else begin
      ref_rise_d <= xtal_rise;
    end
  end

  wire next_up = o_pump_up | ref_rise_d;
  wire next_dn = o_pump_down | (fb_rise & pll_enabled);

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_pump_up <= 1'b0;
      o_pump_down <= 1'b0;
    end else if (!pll_enabled || (next_up && next_dn)) begin
      // both edges seen: end correction
      o_pump_up <= 1'b0;
      o_pump_down <= 1'b0;
    end else begin
      o_pump_up <= next_up;
      o_pump_down <= next_dn;
    end
  end

  // ==========================================================
  // lock detector
  reg [7:0] win_cnt; // reference edges in window
  reg [7:0] fb_cnt; // feedback edges in window
  wire [7:0] fb_tot = fb_cnt + {7'h00, fb_rise};
  wire [7:0] dev = (fb_tot > `CGM_WIN) ? (fb_tot - `CGM_WIN) : (`CGM_WIN - fb_tot);
  wire win_end = ref_rise_d & (win_cnt == (`CGM_WIN - 8'h01));
  reg det_acq; // detector filter mode
  reg det_lock; // detector lock state

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      win_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      det_acq <= 1'b0;
      det_lock <= 1'b0;
    end else if (!pll_enabled) begin
      win_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      det_acq <= 1'b0;
      det_lock <= 1'b0;
    end else if (win_end) begin
      win_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      if (dev <= `CGM_TOL_TRK) begin
        det_acq <= 1'b1;
      end else if (dev > `CGM_TOL_UNT) begin
        det_acq <= 1'b0;
      end
      if (dev <= `CGM_TOL_LOCK) begin
        det_lock <= 1'b1;
      end else if (dev > `CGM_TOL_UNL) begin
        det_lock <= 1'b0;
      end
    end else begin
      if (ref_rise_d) begin
        win_cnt <= win_cnt + 8'h01;
      end
      fb_cnt <= fb_tot;
    end
  end

  // ==========================================================
  // mode, lock and flag
  // tracking unless acquiring
  assign o_track_mode = acquire_track_bit;
  wire pll_control_reg_read = rd & hit_pll_control_reg;
  wire next_lock = auto_bw & det_lock;
  wire lock_toggle = auto_bw & (next_lock != lock_ind);

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      lock_ind <= 1'b0;
      acquire_track_bit <= 1'b0;
      lock_change_flag <= 1'b0;
    end else begin
      lock_ind <= next_lock;
      if (auto_bw) begin
        acquire_track_bit <= det_acq;
      end else if (wr && hit_bandwidth_control_reg) begin
        acquire_track_bit <= i_pwdata[`CGM_BANDWIDTH_CONTROL_REG_ACQ];
      end
      // toggle sets, read clears; set wins
      if (lock_toggle) begin
        lock_change_flag <= 1'b1;
      end else if (pll_control_reg_read || !auto_bw) begin
        lock_change_flag <= 1'b0;
      end
    end
  end

  assign o_clockgen_irq = auto_bw & irq_enable & lock_change_flag;

  // ==========================================================
  // register writes
  wire wr_on = i_pwdata[`CGM_PLL_CONTROL_REG_ON];
  wire wr_bcs = i_pwdata[`CGM_PLL_CONTROL_REG_BCS];
  wire on_chg = (wr_on != pll_power_on);
  wire bcs_chg = (wr_bcs != base_clock_select);

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      irq_enable <= 1'b0;
      pll_power_on <= `CGM_ON_RESET;
      base_clock_select <= 1'b0;
      auto_bw <= 1'b0;
      multiplier_program_reg <= `CGM_PPG_RESET;
    end else begin
      if (wr && hit_pll_control_reg) begin
        // enable writable only in auto mode
        irq_enable <= auto_bw & i_pwdata[`CGM_PLL_CONTROL_REG_IE];
        // power stays on while vco selected
        if (!base_clock_select) begin
          pll_power_on <= wr_on;
        end
        // select only with pll ready, not with power change
        if (!(on_chg && !base_clock_select) && bcs_chg) begin
          base_clock_select <= wr_bcs & pll_enabled;
        end
      end else if (!auto_bw) begin
        irq_enable <= 1'b0;
      end
      if (wr && hit_bandwidth_control_reg) begin
        auto_bw <= i_pwdata[`CGM_BANDWIDTH_CONTROL_REG_AUTO];
      end
      // N upper, L lower; locked while on
      if (wr && hit_ppg && !pll_power_on) begin
        multiplier_program_reg <= i_pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // read data
  // status bits read back from hardware
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= 32'h00000000;
      if (hit_pll_control_reg) begin
        o_prdata[`CGM_PLL_CONTROL_REG_IE] <= irq_enable & auto_bw;
        o_prdata[`CGM_PLL_CONTROL_REG_FLAG] <= lock_change_flag & auto_bw;
        o_prdata[`CGM_PLL_CONTROL_REG_ON] <= pll_power_on;
        o_prdata[`CGM_PLL_CONTROL_REG_BCS] <= bcs_eff;
      end else if (hit_bandwidth_control_reg) begin
        o_prdata[`CGM_BANDWIDTH_CONTROL_REG_AUTO] <= auto_bw;
        o_prdata[`CGM_BANDWIDTH_CONTROL_REG_LOCK] <= lock_ind;
        o_prdata[`CGM_BANDWIDTH_CONTROL_REG_ACQ] <= acquire_track_bit;
      end else if (hit_ppg) begin
        o_prdata[7:0] <= multiplier_program_reg;
      end
    end
  end

  // ==========================================================
  // base clock selector
  localparam ST_RUN = 1'b0; // dividing current source
  localparam ST_SWITCH = 1'b1; // holding output during change
  reg sw_state; // selector state
  reg sel_cur; // source in use, 1 = vco
  reg [1:0] sw_xcnt; // crystal edges seen
  reg [1:0] sw_vcnt; // vco edges seen
  reg [7:0] sw_tmo; // fallback if a source is stopped
  wire src_rise = sel_cur ? vco_rise : xtal_rise;
  wire sw_done = ((sw_xcnt == `CGM_SW_EDGES) && (sw_vcnt == `CGM_SW_EDGES))
    || (sw_tmo == `CGM_SW_TIMEOUT);

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sw_state <= ST_RUN;
      sel_cur <= 1'b0;
      sw_xcnt <= 2'h0;
      sw_vcnt <= 2'h0;
      sw_tmo <= 8'h00;
      o_base_clock_out <= 1'b0;
    end else begin
      case (sw_state)
        ST_RUN: begin
          if (src_rise) begin
            o_base_clock_out <= ~o_base_clock_out;
          end
          if (bcs_eff != sel_cur) begin
            sw_state <= ST_SWITCH;
            sw_xcnt <= 2'h0;
            sw_vcnt <= 2'h0;
            sw_tmo <= 8'h00;
          end
        end
        ST_SWITCH: begin
          if (xtal_rise && sw_xcnt != `CGM_SW_EDGES) begin
            sw_xcnt <= sw_xcnt + 2'h1;
          end
          if (vco_rise_raw && sw_vcnt != `CGM_SW_EDGES) begin
            sw_vcnt <= sw_vcnt + 2'h1;
          end
          sw_tmo <= sw_tmo + 8'h01;
          if (sw_done) begin
            sel_cur <= bcs_eff;
            sw_state <= ST_RUN;
          end
        end
        default: begin
          sw_state <= ST_RUN;
        end
      endcase
    end
  end
endmodule // cgm_pll_ctrl
`default_nettype wire

// ### src/cgm_sync.v
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// three-stage pin synchroniser with agreed-level rise pulse
module cgm_sync (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // pin side
  input wire i_pin,
  // core side
  output reg o_level,
  output wire o_rise
);
  reg s1; // first stage, read only by s2
  reg s2; // second stage
  reg s3; // third stage

  // shift chain and agreed level
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      // change counts once stages two and three agree
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end

  // one-cycle pulse on an agreed rising edge
  assign o_rise = (s2 == s3) & s3 & ~o_level;
endmodule // cgm_sync
`default_nettype wire
